// ### dbc_debug_controller.sv
`include "dbc_regs.svh"
`default_nettype none

// Behaviour
// - Bits travel MSB first, 16 debug clock ticks per bit nominally.
// - 512 ticks without a host edge abort the command, nothing changed.
// - Pin is pseudo-open-drain; each side releases it when not driving.
// - Clock source select picks bus clock or alternate debug clock.
// - Pin timing runs on the debug clock; host edges are synchronised.
// - Pulled-up pin at reset gives normal mode; held low forces background.
// - Serial traffic is accepted any time, no reset needed first.
// - With breakpoint enable set, triggers raise a breakpoint request.
// - Breakpoint kind select chooses tag-type or force-type handling.
// - Tag marks the opcode entering queue; at pipe end halt instead.
// - Force breakpoint finishes current instruction, then enters background.
// - Without debug mode enable, breakpoints run software interrupt instead.
// - Holds an 8-bit status/control and a 16-bit breakpoint address.
// - Both registers reached only by serial commands, never by programs.
// - Debug mode enable writes are ignored during active background mode.
// - Four status bits are read-only, never changed by write-control.
// - Clock source select is readable and writable at any time.
module dbc_debug_controller
  import dbc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic busTick,
  input wire logic altTick,
  input wire logic debugPinIn,
  output logic debugPinOut,
  output logic debugPinOe,
  output logic forceBackgroundMode,
  input wire dbc_cpu_status_t cpuStatus,
  input wire logic breakEnable,
  input wire logic breakKindTag,
  input wire logic triggerIn,
  input wire logic [15:0] cpuAddr,
  input wire logic cpuAddrValid,
  input wire logic opcodeEnter,
  input wire logic tagRetire,
  input wire logic instrDone,
  output logic tagOpcode,
  output logic haltToDebug,
  output logic softwareInterrupt
);

  // ----------------------------------------------------------------
  // Reset release and state
  // ----------------------------------------------------------------
  logic rstMeta_q, rstSync_q, rstN;
  logic pinMeta_q, pinSync_q, pinPrev_q;
  logic [1:0] strapWait_q;
  logic strapDone_q, forceBg_q;
  dbc_state_t state_q, state_d;
  logic [4:0] tickCnt_q, bitsLeft_q;
  logic [9:0] idleCnt_q;
  logic bitActive_q, driveWin_q, driveBit_q, pinOe_q;
  logic [15:0] shift_q, bkpt_q;
  logic [7:0] cmd_q;
  logic modeEn_q, matchEn_q, clkSel_q;
  logic tagOpcode_q, forcePend_q, halt_q, swi_q;

  // Async assert, two-flop synchronous release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  // ----------------------------------------------------------------
  // Pin synchroniser and debug clock selection
  // ----------------------------------------------------------------
  // Host edges are asynchronous; only pinSync_q and later are inspected
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
      pinPrev_q <= 1'b1;
    end else begin
      pinMeta_q <= debugPinIn;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  logic fallEdge, dbgTick, timeout, sampleNow, lastBit, cmdDone, wdataDone;
  logic [15:0] rxWord;
  logic [7:0] scrImage;
  assign fallEdge = pinPrev_q & ~pinSync_q;
  assign dbgTick = clkSel_q ? busTick : altTick;
  assign timeout = (idleCnt_q == `DBC_TIMEOUT_TICKS);
  assign sampleNow = bitActive_q & dbgTick & (tickCnt_q == `DBC_SAMPLE_TICK - 5'd1);
  assign lastBit = sampleNow & (bitsLeft_q == 5'd1);
  assign rxWord = {shift_q[14:0], pinSync_q};
  assign cmdDone = (state_q == ST_CMD) & lastBit & ~timeout;
  assign wdataDone = (state_q == ST_WDATA) & lastBit & ~timeout;
  assign scrImage = {modeEn_q, cpuStatus.bgActive, matchEn_q, 1'b0, clkSel_q,
                     cpuStatus.waitStop, cpuStatus.waitStopFail, cpuStatus.dataValidFail};

  // ----------------------------------------------------------------
  // Reset strap: low pin after release forces background mode
  // ----------------------------------------------------------------
  // Wait for the synchroniser to fill before trusting the pin level
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      strapWait_q <= 2'd0;
      strapDone_q <= 1'b0;
      forceBg_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapWait_q <= strapWait_q + 2'd1;
      if (strapWait_q == 2'd3) begin
        strapDone_q <= 1'b1;
        forceBg_q <= ~pinSync_q;
      end
    end
  end
  assign forceBackgroundMode = forceBg_q;

  // ----------------------------------------------------------------
  // Bit timing: tick counter and inactivity watchdog
  // ----------------------------------------------------------------
  // Tick counter saturates so a stalled bit cannot wrap into a false sample
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      tickCnt_q <= 5'h1f;
      idleCnt_q <= 10'h000;
      bitActive_q <= 1'b0;
    end else begin
      if (fallEdge) begin
        tickCnt_q <= 5'h00;
      end else if (dbgTick && tickCnt_q != 5'h1f) begin
        tickCnt_q <= tickCnt_q + 5'h01;
      end
      if (fallEdge || state_q == ST_IDLE) begin
        idleCnt_q <= 10'h000;
      end else if (dbgTick && !timeout) begin
        idleCnt_q <= idleCnt_q + 10'h001;
      end
      if (fallEdge) begin
        bitActive_q <= 1'b1;
      end else if (sampleNow) begin
        bitActive_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: command byte, then write data or read data
  // ----------------------------------------------------------------
  // Idle accepts a new command at any falling edge, whatever the core is doing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (fallEdge) begin
          state_d = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cmdDone) begin
          case (rxWord[7:0])
            `DBC_CMD_RD_STATUS, `DBC_CMD_RD_BKPT: state_d = ST_RDATA;
            `DBC_CMD_WR_CONTROL, `DBC_CMD_WR_BKPT: state_d = ST_WDATA;
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_WDATA: begin
        if (wdataDone) begin
          state_d = ST_IDLE;
        end
      end
      ST_RDATA: begin
        if (lastBit) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (timeout) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Shifter: received bits enter LSB, transmitted bits leave MSB
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      shift_q <= 16'h0000;
      bitsLeft_q <= 5'd8;
      cmd_q <= 8'h00;
    end else if (state_q == ST_IDLE) begin
      bitsLeft_q <= 5'd8;
    end else if (cmdDone) begin
      cmd_q <= rxWord[7:0];
      case (rxWord[7:0])
        `DBC_CMD_RD_STATUS: begin
          shift_q <= {scrImage, 8'h00};
          bitsLeft_q <= 5'd8;
        end
        `DBC_CMD_RD_BKPT: begin
          shift_q <= bkpt_q;
          bitsLeft_q <= 5'd16;
        end
        `DBC_CMD_WR_CONTROL: bitsLeft_q <= 5'd8;
        `DBC_CMD_WR_BKPT: bitsLeft_q <= 5'd16;
        default: bitsLeft_q <= 5'd8;
      endcase
    end else if (sampleNow) begin
      shift_q <= (state_q == ST_RDATA) ? {shift_q[14:0], 1'b0} : rxWord;
      bitsLeft_q <= bitsLeft_q - 5'd1;
    end
  end

  // ----------------------------------------------------------------
  // Serial-only registers
  // ----------------------------------------------------------------
  // Writes commit only after the final bit, so an abort leaves them intact
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      modeEn_q <= 1'(`DBC_SCR_RESET >> `DBC_SCR_MODE_EN);
      matchEn_q <= 1'(`DBC_SCR_RESET >> `DBC_SCR_MATCH_EN);
      clkSel_q <= 1'(`DBC_SCR_RESET >> `DBC_SCR_CLK_SEL);
      bkpt_q <= `DBC_BKPT_RESET;
    end else if (wdataDone) begin
      if (cmd_q == `DBC_CMD_WR_CONTROL) begin
        if (!cpuStatus.bgActive) begin
          modeEn_q <= rxWord[`DBC_SCR_MODE_EN];
        end
        matchEn_q <= rxWord[`DBC_SCR_MATCH_EN];
        clkSel_q <= rxWord[`DBC_SCR_CLK_SEL];
      end else if (cmd_q == `DBC_CMD_WR_BKPT) begin
        bkpt_q <= rxWord;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin driver: low only, released after the drive window
  // ----------------------------------------------------------------
  // A one bit is left to the pull-up, so the target never fights the host high
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      driveWin_q <= 1'b0;
      driveBit_q <= 1'b1;
      pinOe_q <= 1'b0;
    end else begin
      if (fallEdge && state_q == ST_RDATA) begin
        driveWin_q <= 1'b1;
        driveBit_q <= shift_q[15];
      end else if (timeout || tickCnt_q >= `DBC_DRIVE_END) begin
        driveWin_q <= 1'b0;
      end
      pinOe_q <= driveWin_q & ~driveBit_q & (state_q == ST_RDATA) & ~timeout;
    end
  end
  assign debugPinOut = 1'b0;
  assign debugPinOe = pinOe_q;

  // ----------------------------------------------------------------
  // Hardware breakpoints
  // ----------------------------------------------------------------
  logic addrHit, trigger;
  assign addrHit = matchEn_q & cpuAddrValid & (cpuAddr == bkpt_q);
  assign trigger = breakEnable & (triggerIn | addrHit);

  // Force request waits for the instruction end; a new trigger wins over the clear
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      tagOpcode_q <= 1'b0;
      forcePend_q <= 1'b0;
      halt_q <= 1'b0;
      swi_q <= 1'b0;
    end else begin
      tagOpcode_q <= trigger & breakKindTag & opcodeEnter;
      forcePend_q <= (trigger & ~breakKindTag) | (forcePend_q & ~instrDone);
      halt_q <= (tagRetire | (forcePend_q & instrDone)) & modeEn_q;
      swi_q <= (tagRetire | (forcePend_q & instrDone)) & ~modeEn_q;
    end
  end
  assign tagOpcode = tagOpcode_q;
  assign haltToDebug = halt_q;
  assign softwareInterrupt = swi_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstN);

  a_timeout_to_idle: assert property (timeout |=> state_q == ST_IDLE)
    else $error("timeout did not abort the command");
  a_timeout_no_write: assert property (timeout |=> $stable(bkpt_q) && $stable(modeEn_q))
    else $error("aborted command changed a register");
  a_msb_first_out: assert property ((fallEdge && state_q == ST_RDATA) |=> driveBit_q == $past(shift_q[15]))
    else $error("transmit bit is not the MSB");
  a_pin_released: assert property ((state_q != ST_RDATA) |=> ##1 !debugPinOe)
    else $error("pin driven outside a read");
  a_tick_source: assert property ((!clkSel_q && !altTick && !fallEdge) |=> $stable(tickCnt_q))
    else $error("bit timing ran off the unselected clock");
  a_edge_sync: assert property (($fell(debugPinIn) ##1 !debugPinIn) |-> ##1 fallEdge)
    else $error("host edge not seen two cycles later");
  a_mode_en_lock: assert property (cpuStatus.bgActive |=> modeEn_q == $past(modeEn_q))
    else $error("mode enable changed in background mode");
  a_status_image: assert property ((cmdDone && rxWord[7:0] == `DBC_CMD_RD_STATUS)
    |=> shift_q[14] == $past(cpuStatus.bgActive) && shift_q[8] == $past(cpuStatus.dataValidFail))
    else $error("status read does not show core state");
  a_tag_mark: assert property ((trigger && breakKindTag && opcodeEnter) |=> tagOpcode)
    else $error("tag breakpoint did not mark the opcode");
  a_no_break_off: assert property ((!breakEnable) |=> !tagOpcode)
    else $error("opcode tagged with breakpoints disabled");
  a_tag_halt: assert property ((tagRetire && modeEn_q) |=> haltToDebug && !softwareInterrupt)
    else $error("tagged opcode did not halt to debug");
  a_swi_fallback: assert property ((tagRetire && !modeEn_q) |=> softwareInterrupt && !haltToDebug)
    else $error("disabled debug mode did not take software interrupt");
  a_force_wait: assert property ((forcePend_q && !instrDone && !tagRetire) |=> !haltToDebug && !softwareInterrupt)
    else $error("force breakpoint acted before instruction end");

  c_read_status: cover property (cmdDone && rxWord[7:0] == `DBC_CMD_RD_STATUS ##[1:400] state_q == ST_IDLE);
  c_write_bkpt: cover property (wdataDone && cmd_q == `DBC_CMD_WR_BKPT);
  c_timeout: cover property (timeout && state_q == ST_WDATA);
  c_force_halt: cover property (forcePend_q && instrDone && modeEn_q);

endmodule : dbc_debug_controller

`default_nettype wire

// ### dbc_host_model.sv
`default_nettype none

module dbc_host_model (
  input wire logic clk_sys,
  input wire logic debugPinOe,
  input wire logic debugPinOut,
  input wire logic [2:0] clkPerTick,
  input wire logic [3:0] slackTicks,
  output logic debugPinIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic hostLow = 1'b0;

  // --------------------------------------------------------
  // Wired-AND debug pin
  // --------------------------------------------------------
  // A released pin goes to the pull-up level, never a stale value
  assign debugPinIn = ~hostLow & ~(debugPinOe & ~debugPinOut);

  // Bit timing follows the target's debug clock rate, told by the bench
  task automatic waitTicks(input int n);
    repeat (n * clkPerTick) @(posedge clk_sys);
    #1;
  endtask

  task automatic hold(input logic low);
    hostLow = low;
  endtask

  // Each bit opens with a falling edge; a 1 is a short low, a 0 a long one.
  // Slack stretches the bit so a slow pod is exercised too.
  task automatic xfer(input int n, input logic [15:0] wv, output logic [15:0] rv);
    logic b;
    rv = '0;
    for (int i = n - 1; i >= 0; i--) begin
      b = wv[i];
      hostLow = 1'b1;
      waitTicks(b ? 2 : 12);
      hostLow = ~b;
      // Read back at tick 10: the target stops driving the last bit soon after
      if (b) waitTicks(8);
      rv[i] = debugPinIn;
      waitTicks(b ? 6 : 1);
      hostLow = 1'b0;
      waitTicks((b ? 0 : 3) + int'(slackTicks));
    end
  endtask
endmodule // dbc_host_model

`default_nettype wire

// ### dbc_pkg.sv
`default_nettype none

package dbc_pkg;

  // Serial link sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_WDATA = 2'b10,
    ST_RDATA = 2'b11
  } dbc_state_t;

  // Read-only status reported by the processor core
  typedef struct packed {
    logic bgActive;
    logic waitStop;
    logic waitStopFail;
    logic dataValidFail;
  } dbc_cpu_status_t;

endpackage : dbc_pkg

`default_nettype wire

// ### dbc_regs.svh
`ifndef DBC_REGS_SVH
`define DBC_REGS_SVH

// ----------------------------------------------------------------
// Serial link timing, counted in debug clock ticks
// ----------------------------------------------------------------
`define DBC_BIT_TICKS 5'd16
`define DBC_SAMPLE_TICK 5'd10
`define DBC_DRIVE_END 5'd13
`define DBC_TIMEOUT_TICKS 10'd512

// ----------------------------------------------------------------
// Serial command codes
// ----------------------------------------------------------------
`define DBC_CMD_RD_STATUS 8'h01
`define DBC_CMD_WR_CONTROL 8'h02
`define DBC_CMD_RD_BKPT 8'h03
`define DBC_CMD_WR_BKPT 8'h04

// ----------------------------------------------------------------
// debug_status_control field positions and reset values
// ----------------------------------------------------------------
`define DBC_SCR_MODE_EN 7
`define DBC_SCR_BG_ACTIVE 6
`define DBC_SCR_MATCH_EN 5
`define DBC_SCR_CLK_SEL 3
`define DBC_SCR_WAIT_STOP 2
`define DBC_SCR_WS_FAIL 1
`define DBC_SCR_DV_FAIL 0
`define DBC_SCR_RESET 8'h00
`define DBC_BKPT_RESET 16'h0000

`endif

// ### tb.sv
`default_nettype none

`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin errCount++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb
  import dbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0, rst_b = 1'b0, busTick = 1'b0, altTick = 1'b0, debugPinIn, debugPinOut, debugPinOe;
  logic forceBackgroundMode, breakEnable, breakKindTag, triggerIn, cpuAddrValid, opcodeEnter;
  logic tagRetire, instrDone, tagOpcode, haltToDebug, softwareInterrupt;
  logic [15:0] cpuAddr, bkpt, rv;
  logic [1:0] tickCnt = 2'd0;
  logic [2:0] clkPerTick;
  logic [3:0] slackTicks;
  logic modeEn, matchEn, clkSel;
  dbc_cpu_status_t cpuStatus;
  int errCount = 0, cmpCount = 0, seed;

  dbc_debug_controller uut (.clk_sys(clk_sys), .rst_b(rst_b), .busTick(busTick), .altTick(altTick),
    .debugPinIn(debugPinIn), .debugPinOut(debugPinOut), .debugPinOe(debugPinOe),
    .forceBackgroundMode(forceBackgroundMode), .cpuStatus(cpuStatus), .breakEnable(breakEnable),
    .breakKindTag(breakKindTag), .triggerIn(triggerIn), .cpuAddr(cpuAddr), .cpuAddrValid(cpuAddrValid),
    .opcodeEnter(opcodeEnter), .tagRetire(tagRetire), .instrDone(instrDone), .tagOpcode(tagOpcode),
    .haltToDebug(haltToDebug), .softwareInterrupt(softwareInterrupt));

  dbc_host_model host (.clk_sys(clk_sys), .debugPinOe(debugPinOe), .debugPinOut(debugPinOut),
    .clkPerTick(clkPerTick), .slackTicks(slackTicks), .debugPinIn(debugPinIn));

  // --------------------------------------------------------
  // Clock and debug clock enables
  // --------------------------------------------------------
  always #5 clk_sys = ~clk_sys;

  // Alternate tick every 2 cycles, bus tick every 4, so a wrong select shows
  always @(posedge clk_sys) begin
    #1;
    tickCnt <= tickCnt + 2'd1;
    altTick <= tickCnt[0];
    busTick <= &tickCnt;
  end

  // --------------------------------------------------------
  // Bench helpers
  // --------------------------------------------------------
  function automatic logic [7:0] expStatus(input dbc_cpu_status_t s);
    return {modeEn, s.bgActive, matchEn, 1'b0, clkSel, s.waitStop, s.waitStopFail, s.dataValidFail};
  endfunction

  task automatic stopTest();
    $display("checks %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Command byte then its data bits, back to back
  task automatic cmd(input logic [7:0] c, input int n, input logic [15:0] wv);
    slackTicks = 4'($random(seed)) & 4'h3;
    host.xfer(8, {8'h00, c}, rv);
    host.xfer(n, wv, rv);
  endtask

  task automatic checkStatus();
    cpuStatus = 4'($random(seed));
    cmd(8'h01, 8, 16'hffff);
    `CHK("status", expStatus(cpuStatus), rv[7:0]);
    `CHK("pinRelease", 1'b0, debugPinOe);
  endtask

  // Caller sets cpuStatus, so the background flag decides the enable bit
  task automatic writeCtl(input logic [7:0] v);
    cmd(8'h02, 8, {8'h00, v});
    if (!cpuStatus.bgActive) modeEn = v[7];
    matchEn = v[5];
    clkSel = v[3];
    clkPerTick = clkSel ? 3'd4 : 3'd2;
    checkStatus();
  endtask

  task automatic readBkpt();
    cmd(8'h03, 16, 16'hffff);
    `CHK("bkpt", bkpt, rv);
  endtask

  // Trigger by input or by address match, then retire or finish the instruction
  task automatic brk(input logic tag, input logic en, input logic viaAddr);
    breakKindTag = tag;
    breakEnable = en;
    triggerIn = ~viaAddr;
    cpuAddrValid = viaAddr;
    cpuAddr = bkpt;
    opcodeEnter = 1'b1;
    @(posedge clk_sys);
    #1;
    triggerIn = 1'b0;
    cpuAddrValid = 1'b0;
    opcodeEnter = 1'b0;
    `CHK("tagOpcode", tag & en, tagOpcode);
    repeat (3) @(posedge clk_sys);
    #1;
    tagRetire = tag & en;
    instrDone = ~tag;
    @(posedge clk_sys);
    #1;
    tagRetire = 1'b0;
    instrDone = 1'b0;
    `CHK("halt", en & modeEn, haltToDebug);
    `CHK("swi", en & ~modeEn, softwareInterrupt);
  endtask

  // --------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------
  initial begin
    seed = 32'h4953090b;
    {breakEnable, breakKindTag, triggerIn, cpuAddrValid, opcodeEnter, tagRetire, instrDone} = '0;
    {modeEn, matchEn, clkSel} = '0;
    cpuAddr = 16'h0000;
    bkpt = 16'h0000;
    cpuStatus = 4'h0;
    clkPerTick = 3'd2;
    slackTicks = 4'h0;
    host.hold(1'b1);
    repeat (16) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK("strap", 1'b1, forceBackgroundMode);
    host.hold(1'b0);
    rst_b = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    `CHK("strap", 1'b0, forceBackgroundMode);
    checkStatus();
    readBkpt();
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      cpuStatus = 4'($random(seed));
      writeCtl(8'($random(seed)));
    end
    cpuStatus = 4'h0;
    writeCtl(8'hff);
    cpuStatus = 4'hf;
    writeCtl(8'h00);
    $display("test control done");
    for (int i = 0; i < 3; i++) begin
      bkpt = 16'($random(seed));
      cmd(8'h04, 16, bkpt);
      readBkpt();
    end
    $display("test breakpoint address done");
    for (int m = 0; m < 2; m++) begin
      cpuStatus = 4'h0;
      writeCtl(m == 0 ? 8'ha8 : 8'h20);
      for (int k = 0; k < 4; k++) brk(k[0], k[1], 1'b0);
    end
    brk(1'b1, 1'b1, 1'b1);
    $display("test breakpoints done");
    // Abandoned commands must leave every register untouched
    host.xfer(8, 16'h0004, rv);
    host.xfer(5, 16'h001f, rv);
    repeat (600 * clkPerTick) @(posedge clk_sys);
    #1;
    readBkpt();
    host.xfer(8, 16'h0002, rv);
    host.xfer(7, 16'h007f, rv);
    repeat (600 * clkPerTick) @(posedge clk_sys);
    #1;
    checkStatus();
    host.xfer(8, 16'h0055, rv);
    checkStatus();
    $display("test timeout done");
    stopTest();
  end

  // Longest run is under 36000 cycles; this cuts a hang short
  initial begin
    repeat (90000) @(posedge clk_sys);
    errCount++;
    $display("mismatch watchdog expected %h seen %h", 1'b0, 1'b1);
    stopTest();
  end
endmodule // tb

`default_nettype wire
